// *** rtl/umcr_pkg.sv ***
/*
  Package for the modem control block: register map, field positions,
  prescaler counts, bus state codes and the packed carriers.
  Assumes a single 32-bit AHB-Lite bus and one clock of 200 MHz.
*/
package umcr_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int unsigned IDX_W          = 2;
  localparam logic [1:0]  IDX_MODEM_CTRL = 2'h0;
  localparam logic [1:0]  IDX_INT_ENABLE = 2'h1;
  localparam logic [1:0]  IDX_MODEM_STAT = 2'h2;
  localparam int unsigned ADDR_IDX_LO    = 2;
  localparam int unsigned ADDR_IDX_HI    = 3;
  localparam int unsigned ADDR_HI_LSB    = 4;
  localparam logic [7:0]  MODEM_CTRL_RST = 8'h00;
  localparam logic [3:0]  INT_ENABLE_RST = 4'h0;

  // ------------------------------------------------------------
  // Field positions of modem_control_reg
  // ------------------------------------------------------------
  localparam int unsigned MC_DTR      = 0;
  localparam int unsigned MC_RTS      = 1;
  localparam int unsigned MC_AUX_ONE  = 2;
  localparam int unsigned MC_AUX_TWO  = 3;
  localparam int unsigned MC_LOOP     = 4;
  localparam int unsigned MC_INT_TYPE = 5;
  localparam int unsigned MC_IR_EN    = 6;
  localparam int unsigned MC_CLK_SEL  = 7;

  // Enable bits of interrupt_enable_reg
  localparam int unsigned IE_RX    = 0;
  localparam int unsigned IE_TX    = 1;
  localparam int unsigned IE_LINE  = 2;
  localparam int unsigned IE_MODEM = 3;

  // Modem level order: cts, dsr, ri, dcd
  localparam int unsigned ML_CTS = 0;
  localparam int unsigned ML_DSR = 1;
  localparam int unsigned ML_RI  = 2;
  localparam int unsigned ML_DCD = 3;

  // ------------------------------------------------------------
  // Prescaler
  // ------------------------------------------------------------
  localparam int unsigned PRE_W        = 6;
  localparam int unsigned PRE_BASE_DIV = 16;
  localparam int unsigned PRE_EXTRA    = 4;
  localparam logic [PRE_W-1:0] PRE_LAST_X1 = PRE_W'(PRE_BASE_DIV - 1);
  localparam logic [PRE_W-1:0] PRE_LAST_X4 = PRE_W'(PRE_BASE_DIV * PRE_EXTRA - 1);
  localparam logic [PRE_W-1:0] PRE_STEP    = 6'h01;

  // ------------------------------------------------------------
  // Bus states and carriers
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE      = 4'h1,
    ST_WRITE     = 4'h2,
    ST_READ_WAIT = 4'h4,
    ST_READ_DONE = 4'h8
  } umcr_state_t;

  typedef struct packed {
    logic cts_n;
    logic dsr_n;
    logic dcd_n;
    logic ri_n;
  } umcr_modem_in_t;

  typedef struct packed {
    logic rx_irq;
    logic tx_irq;
    logic line_irq;
  } umcr_core_irq_t;

  typedef struct packed {
    umcr_state_t       state;
    logic              mapped;
    logic [IDX_W-1:0]  idx;
    logic [31:0]       hrdata;
    logic [7:0]        modem_control;
    logic [3:0]        interrupt_enable_reg;
    logic [3:0]        lvl;
    logic [3:0]        delta;
    logic [PRE_W-1:0]  presc;
    logic              tick;
    logic              tx_pin;
    logic              ir_tx;
    logic              rx_core;
    logic              rts_n;
    logic              dtr_n;
    logic              irq_level;
    logic              irq_oe_n;
  } umcr_regs_t;

endpackage

// *** rtl/umcr_top.sv ***
/*
  Modem control register block of a single-channel UART: AHB-Lite slave
  with the control, interrupt enable and modem status registers, baud
  prescaler, IrDA path, loop-back and interrupt pin driver.
  Assumes one clock hclk, pins synchronous to it, and a single slave
  whose hreadyout is the bus hready.
*/
//
// Notes on behaviour
// - Clock select 0 gives the baud generator one tick per 16 clocks.
// - Clock select 1 divides that further by four, one tick per 64.
// - IR enable 0 uses the plain receive and transmit pins.
// - IR enable 1 routes serial data through the IrDA encoder and decoder.
// - In IrDA mode the infrared output is low while the transmitter idles.
// - Interrupt type 0 drives the interrupt pin actively or leaves it floating.
// - Interrupt type 1 drives the pin open source for a wired-OR line.
// - Loop-back cuts the transmit, receive and modem inputs off the pins.
// - Loop-back feeds transmit data and control outputs back internally.
// - Receiver and transmitter interrupts work unchanged in loop-back.
// - Loop-back takes modem status sources from the low four control bits.
// - Every interrupt source stays gated by the interrupt enable register.
// - Loop-back is off after reset.
// - In loop-back, auxiliary output two sets the internal carrier detect.
// - With interrupt type 0, bit 3 low floats the interrupt pin, high drives it; loop carrier follows bit 3.
// - Auxiliary output one sets the internal ring indicator in loop-back.
// - Active-low request-to-send follows the inverse of bit 1.
// - Active-low terminal-ready follows the inverse of bit 0.
`timescale 1ns/1ps

module umcr_top
  import umcr_pkg::*;
(
  input  wire logic           hclk,
  input  wire logic           hresetn,
  input  wire logic           hsel,
  input  wire logic [31:0]    haddr,
  input  wire logic [1:0]     htrans,
  input  wire logic           hwrite,
  input  wire logic [2:0]     hsize,
  input  wire logic [31:0]    hwdata,
  input  wire logic           hready,
  output logic                hreadyout,
  output logic                hresp,
  output logic [31:0]         hrdata,
  input  wire logic           tx_data,
  input  wire logic           tx_idle,
  output logic                rx_data,
  input  wire umcr_core_irq_t core_irq,
  output logic                baud_tick,
  output logic                tx_pin,
  input  wire logic           rx_pin,
  output logic                ir_tx,
  input  wire logic           ir_rx,
  input  wire umcr_modem_in_t modem_in,
  output logic                rts_n,
  output logic                dtr_n,
  output logic                irq_pin_out,
  output logic                irq_pin_oe_n
);

  umcr_regs_t s;
  umcr_regs_t next_s;
  logic [3:0] lvl_now;
  logic [3:0] delta_clr;
  logic       irq_any;
  logic       loop_on;
  logic       ir_on;

  // ------------------------------------------------------------
  // Mode decode and modem level selection
  // ------------------------------------------------------------
  assign loop_on = s.modem_control[MC_LOOP];
  assign ir_on   = s.modem_control[MC_IR_EN];

  always_comb
  begin
    lvl_now = 4'h0;
    if (loop_on)
    begin
      lvl_now[ML_CTS] = s.modem_control[MC_RTS];
      lvl_now[ML_DSR] = s.modem_control[MC_DTR];
      lvl_now[ML_RI]  = s.modem_control[MC_AUX_ONE];
      lvl_now[ML_DCD] = s.modem_control[MC_AUX_TWO];
    end
    else
    begin
      lvl_now[ML_CTS] = ~modem_in.cts_n;
      lvl_now[ML_DSR] = ~modem_in.dsr_n;
      lvl_now[ML_RI]  = ~modem_in.ri_n;
      lvl_now[ML_DCD] = ~modem_in.dcd_n;
    end
  end

  // ------------------------------------------------------------
  // Interrupt gating
  // ------------------------------------------------------------
  assign irq_any = (core_irq.rx_irq   & s.interrupt_enable_reg[IE_RX])
                 | (core_irq.tx_irq   & s.interrupt_enable_reg[IE_TX])
                 | (core_irq.line_irq & s.interrupt_enable_reg[IE_LINE])
                 | ((|s.delta)        & s.interrupt_enable_reg[IE_MODEM]);

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    next_s    = s;
    delta_clr = 4'h0;

    // Baud prescaler
    next_s.tick = 1'b0;
    if (s.presc == (s.modem_control[MC_CLK_SEL] ? PRE_LAST_X4 : PRE_LAST_X1))
    begin
      next_s.presc = '0;
      next_s.tick  = 1'b1;
    end
    else
    begin
      next_s.presc = s.presc + PRE_STEP;
    end

    // Serial path
    if (loop_on)
    begin
      next_s.tx_pin  = 1'b1;
      next_s.ir_tx   = 1'b0;
      next_s.rx_core = tx_data;
    end
    else if (ir_on)
    begin
      next_s.tx_pin  = 1'b1;
      next_s.ir_tx   = ~tx_idle & ~tx_data;
      next_s.rx_core = ~ir_rx;
    end
    else
    begin
      next_s.tx_pin  = tx_data;
      next_s.ir_tx   = 1'b0;
      next_s.rx_core = rx_pin;
    end

    // Handshake outputs
    next_s.rts_n = ~s.modem_control[MC_RTS];
    next_s.dtr_n = ~s.modem_control[MC_DTR];

    // Interrupt pin driver
    if (s.modem_control[MC_INT_TYPE])
    begin
      next_s.irq_level = 1'b1;
      next_s.irq_oe_n  = ~irq_any;
    end
    else
    begin
      next_s.irq_level = irq_any;
      next_s.irq_oe_n  = ~s.modem_control[MC_AUX_TWO];
    end

    // Bus slave
    unique case (s.state)
      ST_WRITE:
      begin
        if (s.mapped && s.idx == IDX_MODEM_CTRL)
        begin
          next_s.modem_control = hwdata[7:0];
        end
        if (s.mapped && s.idx == IDX_INT_ENABLE)
        begin
          next_s.interrupt_enable_reg = hwdata[3:0];
        end
      end
      ST_READ_WAIT:
      begin
        next_s.hrdata = 32'h0000_0000;
        if (s.mapped)
        begin
          unique case (s.idx)
            IDX_MODEM_CTRL: next_s.hrdata[7:0] = s.modem_control;
            IDX_INT_ENABLE: next_s.hrdata[3:0] = s.interrupt_enable_reg;
            IDX_MODEM_STAT:
            begin
              next_s.hrdata[7:0] = {s.lvl, s.delta};
              delta_clr          = s.delta;
            end
            default: next_s.hrdata = 32'h0000_0000;
          endcase
        end
      end
      ST_IDLE, ST_READ_DONE:
      begin
      end
    endcase

    if (s.state == ST_READ_WAIT)
    begin
      next_s.state = ST_READ_DONE;
    end
    else if (hsel && htrans[1] && hready)
    begin
      next_s.state  = hwrite ? ST_WRITE : ST_READ_WAIT;
      next_s.idx    = haddr[ADDR_IDX_HI:ADDR_IDX_LO];
      next_s.mapped = (haddr[31:ADDR_HI_LSB] == '0)
                   && (haddr[ADDR_IDX_HI:ADDR_IDX_LO] <= IDX_MODEM_STAT);
    end
    else
    begin
      next_s.state = ST_IDLE;
    end

    // Modem status deltas: a new change wins over the read clear
    next_s.lvl   = lvl_now;
    next_s.delta = (s.delta & ~delta_clr) | (lvl_now ^ s.lvl);
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s.state     <= ST_IDLE;
      s.mapped    <= 1'b0;
      s.idx       <= '0;
      s.hrdata    <= 32'h0000_0000;
      s.modem_control       <= MODEM_CTRL_RST;
      s.interrupt_enable_reg       <= INT_ENABLE_RST;
      s.lvl       <= 4'h0;
      s.delta     <= 4'h0;
      s.presc     <= '0;
      s.tick      <= 1'b0;
      s.tx_pin    <= 1'b1;
      s.ir_tx     <= 1'b0;
      s.rx_core   <= 1'b1;
      s.rts_n     <= 1'b1;
      s.dtr_n     <= 1'b1;
      s.irq_level <= 1'b0;
      s.irq_oe_n  <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign hreadyout    = (s.state != ST_READ_WAIT);
  assign hresp        = 1'b0;
  assign hrdata       = s.hrdata;
  assign baud_tick    = s.tick;
  assign tx_pin       = s.tx_pin;
  assign ir_tx        = s.ir_tx;
  assign rx_data      = s.rx_core;
  assign rts_n        = s.rts_n;
  assign dtr_n        = s.dtr_n;
  assign irq_pin_out  = s.irq_level;
  assign irq_pin_oe_n = s.irq_oe_n;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking chk_clk @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence mc_write_seq;
    s.state == ST_WRITE && s.mapped && s.idx == IDX_MODEM_CTRL;
  endsequence

  sequence loop_hold_seq;
    loop_on && $stable(s.modem_control);
  endsequence

  chk_prescale_by_sixteen: assert property (
    (s.presc == PRE_LAST_X1 && !s.modem_control[MC_CLK_SEL]) |=> baud_tick ##1 !baud_tick)
    else $error("Prescaler missed tick at count sixteen");

  chk_prescale_by_four: assert property (
    (s.presc == PRE_LAST_X1 && s.modem_control[MC_CLK_SEL]) |=> !baud_tick)
    else $error("Prescaler ticked early in divide-by-four mode");

  chk_ir_idle_low: assert property (
    (tx_idle || !ir_on) |=> !ir_tx)
    else $error("Infrared output not low while idle");

  chk_loop_tx_idle: assert property (
    loop_on |=> tx_pin && !ir_tx)
    else $error("Transmit pin left idle level in loop-back");

  chk_loop_levels: assert property (
    loop_hold_seq |=> s.lvl == {$past(s.modem_control[MC_AUX_TWO]), $past(s.modem_control[MC_AUX_ONE]),
                                $past(s.modem_control[MC_DTR]), $past(s.modem_control[MC_RTS])})
    else $error("Loop-back modem levels do not follow control bits");

  chk_handshake_pins: assert property (
    ##1 (rts_n == !$past(s.modem_control[MC_RTS]) && dtr_n == !$past(s.modem_control[MC_DTR])))
    else $error("Handshake pins disagree with control bits");

  chk_open_source: assert property (
    (s.modem_control[MC_INT_TYPE] && irq_any) |=> (!irq_pin_oe_n && irq_pin_out))
    else $error("Open source interrupt not driven high");

  chk_int_float: assert property (
    (!s.modem_control[MC_INT_TYPE] && !s.modem_control[MC_AUX_TWO]) |=> irq_pin_oe_n)
    else $error("Interrupt pin driven while it should float");

  chk_write_readback: assert property (
    mc_write_seq |=> s.modem_control == $past(hwdata[7:0]))
    else $error("Control register did not take written value");

  chk_modem_gate: assert property (
    (!s.interrupt_enable_reg[IE_MODEM] && !s.interrupt_enable_reg[IE_RX] && !s.interrupt_enable_reg[IE_TX] && !s.interrupt_enable_reg[IE_LINE]
     && !s.modem_control[MC_INT_TYPE]) |=> !irq_pin_out)
    else $error("Interrupt raised with all sources disabled");

  chk_read_wait: assert property (
    (s.state == ST_READ_WAIT) |-> !hreadyout ##1 hreadyout)
    else $error("Read data phase not exactly one wait state");

  chk_normal_path: assert property (
    (!loop_on && !ir_on) |=> (tx_pin == $past(tx_data) && rx_data == $past(rx_pin) && !ir_tx))
    else $error("Plain serial path does not follow the pins");

  chk_ir_decode: assert property (
    (!loop_on && ir_on) |=> (tx_pin && rx_data == !$past(ir_rx)))
    else $error("Infrared path does not decode the receive input");

  chk_loop_rx_echo: assert property (
    loop_on |=> rx_data == $past(tx_data))
    else $error("Loop-back receive data does not echo transmit data");

  chk_int_active: assert property (
    (!s.modem_control[MC_INT_TYPE] && s.modem_control[MC_AUX_TWO])
    |=> (!irq_pin_oe_n && irq_pin_out == $past(irq_any)))
    else $error("Active interrupt pin does not follow the interrupt");

  chk_delta_capture: assert property (
    (lvl_now != s.lvl) |=> (s.delta != 4'h0))
    else $error("Modem level change not flagged");

  chk_tick_single: assert property (
    baud_tick |=> !baud_tick)
    else $error("Baud tick longer than one clock");

endmodule

// *** tb/umcr_modem_model.sv ***
/*
  Modem side model: clear-to-send answers request-to-send and
  set-ready answers terminal-ready one clock later; carrier, ring
  and line level come from the bench.
  Assumes pins synchronous to hclk.
*/
`timescale 1ns/1ps
module umcr_modem_model
  import umcr_pkg::*;
(
  input  wire logic      hclk,
  input  wire logic      rts_n,
  input  wire logic      dtr_n,
  input  wire logic      dcd_n,
  input  wire logic      ri_n,
  input  wire logic      line,
  output umcr_modem_in_t modem_in,
  output logic           rx_pin,
  output logic           ir_rx
);
  // ----
  // Modem answers
  // ----
  always @(posedge hclk)
    modem_in <= '{cts_n: rts_n, dsr_n: dtr_n, dcd_n: dcd_n, ri_n: ri_n};
  assign rx_pin = line;
  assign ir_rx  = ~line;
endmodule

// *** tb/tb_uart_modem_control_register.sv ***
/*
  Bench for the modem control block: reset values, pin cases from a table,
  then prescaler, loop-back status, interrupt pin and reset cases.
  Assumes the AHB-Lite map and one-cycle pin lag of the design.
*/
`timescale 1ns/1ps
module tb_uart_modem_control_register
  import umcr_pkg::*;
;
  logic           hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic           tx_data = 1, tx_idle = 1, dcd_n = 1, ri_n = 1, line = 0;
  logic [1:0]     htrans = 2'h0;
  logic [31:0]    haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic           hready, hreadyout, hresp, rx_data, baud_tick, tx_pin;
  logic           rx_pin, ir_tx, ir_rx, rts_n, dtr_n, irq_pin_out, irq_pin_oe_n;
  umcr_core_irq_t core_irq = 3'h0;
  umcr_modem_in_t modem_in;
  int             num_errors = 0, num_checks = 0;
  typedef struct packed {
    logic [7:0] modem_control;
    logic [2:0] in;
    logic [4:0] exp;
  } umcr_row_t;
  umcr_row_t rows [6] = '{'{8'h00, 3'b001, 5'b11001}, '{8'h03, 3'b100, 5'b00100},
    '{8'h40, 3'b000, 5'b11110}, '{8'h40, 3'b111, 5'b11101},
    '{8'h10, 3'b001, 5'b11100}, '{8'h50, 3'b100, 5'b11101}};

  always #2.5 hclk = ~hclk;
  assign hready = hreadyout;

  umcr_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tx_data(tx_data),
    .tx_idle(tx_idle), .rx_data(rx_data), .core_irq(core_irq), .baud_tick(baud_tick),
    .tx_pin(tx_pin), .rx_pin(rx_pin), .ir_tx(ir_tx), .ir_rx(ir_rx),
    .modem_in(modem_in), .rts_n(rts_n), .dtr_n(dtr_n), .irq_pin_out(irq_pin_out),
    .irq_pin_oe_n(irq_pin_oe_n));

  umcr_modem_model modem (.hclk(hclk), .rts_n(rts_n), .dtr_n(dtr_n), .dcd_n(dcd_n),
    .ri_n(ri_n), .line(line), .modem_in(modem_in), .rx_pin(rx_pin), .ir_rx(ir_rx));

  // ----
  // Checks, bus cycles and waits
  // ----
  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    num_checks++;
    if (act !== exp)
    begin
      num_errors++;
      $display("mismatch t=%0t act=%h exp=%h", $time, act, exp);
    end
  endtask

  task automatic chk_irq(input logic [1:0] exp);
    repeat (3) @(posedge hclk);
    chk({30'h0, irq_pin_oe_n, irq_pin_out}, {30'h0, exp});
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        num_errors++;
        end_of_test();
      end
      @(posedge hclk);
    end
  endtask

  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic tick_gap(input int exp);
    int n;
    n = 0;
    while (baud_tick !== 1'b1 && n < 100)
    begin
      n++;
      @(posedge hclk);
    end
    n = 1;
    @(posedge hclk);
    while (baud_tick !== 1'b1 && n < 100)
    begin
      n++;
      @(posedge hclk);
    end
    chk(n, exp);
  endtask

  // ----
  // Main sequence
  // ----
  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk({26'h0, rts_n, dtr_n, tx_pin, ir_tx, rx_data, irq_pin_oe_n}, 32'h39);
    xfer(1'b0, 32'h0, 32'h0);
    chk(rd, 32'h0);
    foreach (rows[i])
    begin
      xfer(1'b1, 32'h0, {24'h0, rows[i].modem_control});
      tx_data <= rows[i].in[2];
      tx_idle <= rows[i].in[1];
      line    <= rows[i].in[0];
      repeat (3) @(posedge hclk);
      chk({rts_n, dtr_n, tx_pin, ir_tx, rx_data}, rows[i].exp);
      xfer(1'b0, 32'h0, 32'h0);
      chk(rd, {24'h0, rows[i].modem_control});
    end
    xfer(1'b1, 32'h0, 32'h80);
    tick_gap(64);
    xfer(1'b1, 32'h0, 32'h10);
    tick_gap(16);
    xfer(1'b1, 32'h4, 32'h0);
    dcd_n <= 1'b0;
    xfer(1'b0, 32'h8, 32'h0);
    xfer(1'b0, 32'h8, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b1, 32'h4, 32'h8);
    xfer(1'b1, 32'h0, 32'h18);
    chk_irq(2'b01);
    xfer(1'b0, 32'h8, 32'h0);
    chk(rd, 32'h88);
    chk_irq(2'b00);
    xfer(1'b1, 32'h4, 32'h0);
    xfer(1'b1, 32'h0, 32'h1e);
    chk_irq(2'b00);
    xfer(1'b0, 32'h8, 32'h0);
    chk({rd[7:4], rd[0]}, 5'b11011);
    core_irq <= 3'b100;
    xfer(1'b1, 32'h4, 32'h1);
    chk_irq(2'b01);
    xfer(1'b1, 32'h0, 32'h30);
    chk_irq(2'b01);
    xfer(1'b1, 32'h0, 32'h10);
    chk_irq(2'b11);
    core_irq <= 3'b010;
    xfer(1'b1, 32'h4, 32'h2);
    xfer(1'b1, 32'h0, 32'h30);
    chk_irq(2'b01);
    core_irq <= 3'b000;
    chk_irq(2'b11);
    xfer(1'b1, 32'hc, 32'hff);
    xfer(1'b0, 32'hc, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b0, 32'h0, 32'h0);
    chk(rd, 32'h30);
    xfer(1'b0, 32'h10, 32'h0);
    chk({rd[31:1], hresp}, 32'h0);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk({26'h0, rts_n, dtr_n, tx_pin, ir_tx, rx_data, irq_pin_oe_n}, 32'h39);
    xfer(1'b0, 32'h0, 32'h0);
    chk(rd, 32'h0);
    end_of_test();
  end
endmodule
